// [rtl/apc_cfg_bank.sv]
// Battery-backed APC configuration bank: RAM guard, century match, pin mux, event triggers
`timescale 1ns/10ps
`include "apc_cfg_consts.svh"

module apc_cfg_bank #(
  parameter int unsigned BLINK_HALF_CYCLES = `LED_BLINK_HALF_CYCLES
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       master_reset_pin,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [7:0]                 reg_rdata,
  input  wire apc_cfg_pkg::ram_access_type ram_req,
  input  wire logic [7:0]                 ram_rdata_raw,
  output logic                            ram_wr_allow,
  output logic      [7:0]                 ram_rdata,
  input  wire logic [7:0]                 century_now,
  output logic                            century_match,
  input  wire logic                       pad_pme_a_gp16,
  input  wire logic                       pad_pme_b_gp15,
  input  wire logic                       pad_irrx_a_gp24,
  input  wire logic                       pad_irrx_b_gp37,
  input  wire logic                       pad_ri_b_gp33,
  input  wire logic                       pad_gp_pin_ten,
  input  wire logic                       gp_pin_twelve,
  input  wire logic                       chip_select_zero,
  output logic                            pm_event_in_a,
  output logic                            pm_event_in_b,
  output logic                            gp_pin_sixteen,
  output logic                            gp_pin_fifteen,
  output logic                            infrared_rx_a,
  output logic                            infrared_rx_b,
  output logic                            gp_pin_twentyfour,
  output logic                            gp_pin_thirtyseven,
  output logic                            ring_indicate_b,
  output logic                            gp_pin_thirtythree,
  output logic                            led_cs_pin_out,
  output logic                            led_cs_pin_oe,
  output apc_cfg_pkg::event_hit_type      event_hit
);

  // A zero half period gives the blink divider nothing to count
  if (BLINK_HALF_CYCLES < 1) begin : g_blink_range
    $error("BLINK_HALF_CYCLES must be at least one");
  end

  localparam int NPIN = 7;

  // Common level/edge trigger decode; reserved codes never fire
  function automatic logic trig_hit(input logic [2:0] code, input logic cur, input logic prev);
    logic hit;
    hit = 1'b0;
    case (code)
      apc_cfg_pkg::TRIG_LOW_LEVEL:  hit = ~cur;
      apc_cfg_pkg::TRIG_HIGH_LEVEL: hit = cur;
      apc_cfg_pkg::TRIG_FALLING:    hit = prev & ~cur;
      apc_cfg_pkg::TRIG_RISING:     hit = ~prev & cur;
      apc_cfg_pkg::TRIG_ANY_EDGE:   hit = prev ^ cur;
      default:                      hit = 1'b0;
    endcase
    return hit;
  endfunction : trig_hit

  // Pin synchronisers: a change counts once stages two and three agree
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic [NPIN-1:0] sync3_q;
  logic [NPIN-1:0] pin_q;
  logic [NPIN-1:0] pin_raw;

  assign pin_raw = {master_reset_pin, pad_gp_pin_ten, pad_ri_b_gp33, pad_irrx_b_gp37,
                    pad_irrx_a_gp24, pad_pme_b_gp15, pad_pme_a_gp16};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Agree filter keeps a one-cycle glitch out of pin_q
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_q <= '0;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          pin_q[i] <= sync3_q[i];
        end
      end
    end
  end

  logic mr_q;
  assign mr_q = pin_q[6];

  // Register file; rst models first power-up only
  logic [7:0] ram_lock_control_q;
  logic [7:0] wake_century_compare_q;
  logic [7:0] pin_designation_config_q;
  logic [7:0] led_and_pme_event_config_q;
  logic [7:0] infrared_event_config_q;
  logic [7:0] gpio_event_wake_config_q;

  // Lock bits only ever set by software; master reset wins a same-cycle write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ram_lock_control_q <= `RST_RAM_LOCK_CONTROL;
    end else if (mr_q) begin
      ram_lock_control_q <= `RST_RAM_LOCK_CONTROL;
    end else if (reg_wr && reg_addr == `ADDR_RAM_LOCK_CONTROL) begin
      ram_lock_control_q <= ram_lock_control_q | (reg_wdata & `RLR_IMPLEMENTED_MASK);
    end
  end

  // Master reset never reaches these
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_century_compare_q     <= `RST_WAKE_CENTURY;
      pin_designation_config_q   <= `RST_PIN_DESIGNATION;
      led_and_pme_event_config_q <= `RST_LED_PME_EVENT;
      infrared_event_config_q    <= `RST_INFRARED_EVENT;
      gpio_event_wake_config_q   <= `RST_GPIO_EVENT_WAKE;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_WAKE_CENTURY:    wake_century_compare_q     <= reg_wdata;
        `ADDR_PIN_DESIGNATION: pin_designation_config_q   <= reg_wdata;
        `ADDR_LED_PME_EVENT:   led_and_pme_event_config_q <= reg_wdata;
        `ADDR_INFRARED_EVENT:  infrared_event_config_q    <= reg_wdata & `IR_RESERVED_MASK;
        `ADDR_GPIO_EVENT_WAKE: gpio_event_wake_config_q   <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data stands for exactly one cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `ADDR_RAM_LOCK_CONTROL: rd_mux = ram_lock_control_q;
      `ADDR_WAKE_CENTURY:     rd_mux = wake_century_compare_q;
      `ADDR_PIN_DESIGNATION:  rd_mux = pin_designation_config_q;
      `ADDR_LED_PME_EVENT:    rd_mux = led_and_pme_event_config_q;
      `ADDR_INFRARED_EVENT:   rd_mux = infrared_event_config_q;
      `ADDR_GPIO_EVENT_WAKE:  rd_mux = gpio_event_wake_config_q;
      default:                rd_mux = `UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // RAM access guard
  logic upper_blk;
  logic rd_blk;
  logic wr_blk;
  logic mask_wr;
  logic lock;
  logic in_first32;
  logic in_lock_win;
  logic wr_block_all;
  logic rd_block_all;

  assign upper_blk   = ram_lock_control_q[`RLR_UPPER_BLOCK_BIT];
  assign rd_blk      = ram_lock_control_q[`RLR_READ_BLOCK_BIT];
  assign wr_blk      = ram_lock_control_q[`RLR_WRITE_BLOCK_BIT];
  assign mask_wr     = ram_lock_control_q[`RLR_MASK_WRITE_BIT];
  assign lock        = ram_lock_control_q[`RLR_LOCK_BIT];
  assign in_first32  = ram_req.upper && (ram_req.offset <= `UPPER_BLOCK_LAST);
  // Lock window applies to direct bank locations, not the upper data port
  assign in_lock_win = !ram_req.upper && (ram_req.offset >= `LOW_RAM_LOCK_FIRST)
                       && (ram_req.offset <= `LOW_RAM_LOCK_LAST);

  assign wr_block_all = (ram_req.upper && upper_blk)
                      || (in_first32 && wr_blk)
                      || (mask_wr && (ram_req.upper || ram_req.bank == 2'h0))
                      || (in_lock_win && lock);
  assign rd_block_all = (ram_req.upper && upper_blk)
                      || (in_first32 && rd_blk)
                      || (in_lock_win && lock);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ram_wr_allow <= 1'b0;
    end else begin
      ram_wr_allow <= ram_req.wr && !wr_block_all;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ram_rdata <= 8'h00;
    end else if (ram_req.rd) begin
      ram_rdata <= rd_block_all ? `RAM_BLOCKED_READ : ram_rdata_raw;
    end
  end

  // Century compare
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      century_match <= 1'b0;
    end else begin
      century_match <= (wake_century_compare_q[7:6] == `CENT_DONT_CARE)
                     || (wake_century_compare_q[`CENT_VALUE_MSB:0]
                         == century_now[`CENT_VALUE_MSB:0]);
    end
  end

  // Pin designation routing; the unselected function reads idle low
  logic sel_pme_a;
  logic sel_pme_b;
  logic sel_led;
  logic sel_gp24;
  logic sel_gp37;
  logic sel_gp33;

  assign sel_pme_a = pin_designation_config_q[`PD_PME_A_BIT];
  assign sel_pme_b = pin_designation_config_q[`PD_PME_B_BIT];
  assign sel_led   = pin_designation_config_q[`PD_LED_BIT];
  assign sel_gp24  = pin_designation_config_q[`PD_GP24_BIT];
  assign sel_gp37  = pin_designation_config_q[`PD_GP37_BIT];
  assign sel_gp33  = infrared_event_config_q[`IR_GP33_BIT];

  // Event enables of deselected inputs are software's job; the mux does not gate them
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pm_event_in_a      <= 1'b0;
      gp_pin_sixteen     <= 1'b0;
      pm_event_in_b      <= 1'b0;
      gp_pin_fifteen     <= 1'b0;
      infrared_rx_a      <= 1'b0;
      gp_pin_twentyfour  <= 1'b0;
      infrared_rx_b      <= 1'b0;
      gp_pin_thirtyseven <= 1'b0;
      ring_indicate_b    <= 1'b0;
      gp_pin_thirtythree <= 1'b0;
    end else begin
      pm_event_in_a      <= sel_pme_a & pin_q[0];
      gp_pin_sixteen     <= ~sel_pme_a & pin_q[0];
      pm_event_in_b      <= sel_pme_b & pin_q[1];
      gp_pin_fifteen     <= ~sel_pme_b & pin_q[1];
      infrared_rx_a      <= ~sel_gp24 & pin_q[2];
      gp_pin_twentyfour  <= sel_gp24 & pin_q[2];
      infrared_rx_b      <= ~sel_gp37 & pin_q[3];
      gp_pin_thirtyseven <= sel_gp37 & pin_q[3];
      ring_indicate_b    <= ~sel_gp33 & pin_q[4];
      gp_pin_thirtythree <= sel_gp33 & pin_q[4];
    end
  end

  // LED blink: free-running half-period counter
  logic [31:0] blink_cnt_q;
  logic        blink_q;
  logic        blink_wrap;

  assign blink_wrap = (blink_cnt_q == BLINK_HALF_CYCLES - 1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      blink_cnt_q <= 32'h0000_0000;
    end else if (blink_wrap) begin
      blink_cnt_q <= 32'h0000_0000;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  // Free-running, so the first phase after a mode change is not aligned
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      blink_q <= 1'b0;
    end else if (blink_wrap) begin
      blink_q <= ~blink_q;
    end
  end

  apc_cfg_pkg::led_mode_type led_mode;
  assign led_mode = apc_cfg_pkg::led_mode_type'(led_and_pme_event_config_q[7:`LED_MODE_LSB]);

  // Reserved LED mode floats, the safest choice for an undefined setting
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      led_cs_pin_out <= 1'b0;
      led_cs_pin_oe  <= 1'b0;
    end else if (!sel_led) begin
      led_cs_pin_out <= chip_select_zero;
      led_cs_pin_oe  <= 1'b1;
    end else begin
      case (led_mode)
        apc_cfg_pkg::LED_DRIVE_0: begin
          led_cs_pin_out <= 1'b0;
          led_cs_pin_oe  <= 1'b1;
        end
        apc_cfg_pkg::LED_BLINK: begin
          led_cs_pin_out <= blink_q;
          led_cs_pin_oe  <= 1'b1;
        end
        default: begin
          led_cs_pin_out <= 1'b0;
          led_cs_pin_oe  <= 1'b0;
        end
      endcase
    end
  end

  // Event trigger detection on routed inputs, synchronised gp pin ten and raw gp_pin_twelve
  logic [5:0] ev_cur;
  logic [5:0] ev_prev_q;

  assign ev_cur = {pin_q[5], pm_event_in_a, pm_event_in_b,
                   infrared_rx_a, infrared_rx_b, gp_pin_twelve};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ev_prev_q <= '0;
    end else begin
      ev_prev_q <= ev_cur;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      event_hit <= '0;
    end else begin
      event_hit.gp_pin_ten    <= trig_hit(pin_designation_config_q[7:`PD_GP10_TRIG_LSB],
                                          ev_cur[5], ev_prev_q[5]);
      event_hit.pm_event_in_a <= trig_hit(led_and_pme_event_config_q[2:`TRIG_LO_LSB],
                                          ev_cur[4], ev_prev_q[4]);
      event_hit.pm_event_in_b <= trig_hit(led_and_pme_event_config_q[5:`TRIG_HI_LSB],
                                          ev_cur[3], ev_prev_q[3]);
      event_hit.infrared_rx_a <= trig_hit(infrared_event_config_q[2:`TRIG_LO_LSB],
                                          ev_cur[2], ev_prev_q[2]);
      event_hit.infrared_rx_b <= trig_hit(infrared_event_config_q[5:`TRIG_HI_LSB],
                                          ev_cur[1], ev_prev_q[1]);
      event_hit.gp_pin_twelve <= trig_hit(gpio_event_wake_config_q[2:`TRIG_LO_LSB],
                                          ev_cur[0], ev_prev_q[0]);
    end
  end

endmodule : apc_cfg_bank

// [rtl/apc_cfg_consts.svh]
// Offsets, field positions, reset values and timing counts of the APC config bank
`ifndef APC_CFG_CONSTS_SVH
`define APC_CFG_CONSTS_SVH

`define ADDR_RAM_LOCK_CONTROL   8'h47
`define ADDR_WAKE_CENTURY       8'h48
`define ADDR_PIN_DESIGNATION    8'h49
`define ADDR_LED_PME_EVENT      8'h4A
`define ADDR_INFRARED_EVENT     8'h4B
`define ADDR_GPIO_EVENT_WAKE    8'h4C

`define RST_PIN_DESIGNATION     8'hA0
`define RST_LED_PME_EVENT       8'h2D
`define RST_INFRARED_EVENT      8'h2D
`define RST_GPIO_EVENT_WAKE     8'h2D
`define RST_RAM_LOCK_CONTROL    8'h00
`define RST_WAKE_CENTURY        8'h00
`define UNMAPPED_READ           8'h00
`define RAM_BLOCKED_READ        8'hFF

`define RLR_UPPER_BLOCK_BIT     3
`define RLR_READ_BLOCK_BIT      4
`define RLR_WRITE_BLOCK_BIT     5
`define RLR_MASK_WRITE_BIT      6
`define RLR_LOCK_BIT            7
`define RLR_IMPLEMENTED_MASK    8'hF8

`define CENT_VALUE_MSB          5
`define CENT_DONT_CARE          2'h3

`define PD_PME_A_BIT            0
`define PD_PME_B_BIT            1
`define PD_LED_BIT              2
`define PD_GP24_BIT             3
`define PD_GP37_BIT             4
`define PD_GP10_TRIG_LSB        5
`define IR_GP33_BIT             6
`define IR_RESERVED_MASK        8'h7F
`define TRIG_LO_LSB             0
`define TRIG_HI_LSB             3
`define LED_MODE_LSB            6

`define LOW_RAM_LOCK_FIRST      7'h38
`define LOW_RAM_LOCK_LAST       7'h3F
`define UPPER_BLOCK_LAST        7'h1F

`define CLK_SYS_KHZ             20000
`define LED_BLINK_PERIOD_MS     1000
`define LED_BLINK_HALF_CYCLES   ((`LED_BLINK_PERIOD_MS * `CLK_SYS_KHZ) / 2)

`endif

// [rtl/apc_cfg_pkg.sv]
// Types shared by the APC configuration bank
package apc_cfg_pkg;

  typedef enum logic [2:0] {
    TRIG_LOW_LEVEL  = 3'h0,
    TRIG_HIGH_LEVEL = 3'h1,
    TRIG_FALLING    = 3'h5,
    TRIG_RISING     = 3'h6,
    TRIG_ANY_EDGE   = 3'h7
  } trig_code_type;

  typedef enum logic [1:0] {
    LED_HIGH_Z  = 2'h0,
    LED_DRIVE_0 = 2'h1,
    LED_BLINK   = 2'h2,
    LED_RSVD    = 2'h3
  } led_mode_type;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       upper;
    logic [1:0] bank;
    logic [6:0] offset;
  } ram_access_type;

  typedef struct packed {
    logic gp_pin_ten;
    logic pm_event_in_a;
    logic pm_event_in_b;
    logic infrared_rx_a;
    logic infrared_rx_b;
    logic gp_pin_twelve;
  } event_hit_type;

endpackage : apc_cfg_pkg

// [tb/apc_cfg_bank_assertions.sv]
// Port checker for the APC configuration bank
`timescale 1ns/10ps
module apc_cfg_bank_checker (
  input wire logic                        clk_sys,
  input wire logic                        rst,
  input wire logic                        master_reset_pin,
  input wire logic [7:0]                  reg_addr,
  input wire logic [7:0]                  reg_wdata,
  input wire logic                        reg_wr,
  input wire apc_cfg_pkg::ram_access_type ram_req,
  input wire logic                        ram_wr_allow,
  input wire logic [7:0]                  ram_rdata,
  input wire logic [7:0]                  century_now,
  input wire logic                        century_match,
  input wire logic                        led_cs_pin_out,
  input wire logic                        led_cs_pin_oe
);
  logic [7:0] lock_q;
  logic [7:0] cent_q;
  logic [7:0] pin_q;
  logic [7:0] led_q;
  logic       low_win;
  logic       up_low;
  logic       cent_hit;
  assign low_win  = !ram_req.upper && ram_req.offset[6:3] == 4'h7;
  assign up_low   = ram_req.upper && ram_req.offset[6:5] == 2'h0;
  assign cent_hit = cent_q[7:6] == 2'h3 || cent_q[5:0] == century_now[5:0];
  // Shadow clears while the pin is high, ahead of the design's synchroniser
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_q <= 8'h00;
    end else if (master_reset_pin) begin
      lock_q <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h47) begin
      lock_q <= lock_q | (reg_wdata & 8'hF8);
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cent_q <= 8'h00;
      pin_q  <= 8'hA0;
      led_q  <= 8'h2D;
    end else if (reg_wr) begin
      if (reg_addr == 8'h48) cent_q <= reg_wdata;
      if (reg_addr == 8'h49) pin_q <= reg_wdata;
      if (reg_addr == 8'h4A) led_q <= reg_wdata;
    end
  end
  sequence s_wr(c);
    ram_req.wr && c;
  endsequence
  sequence s_rd(c);
    ram_req.rd && c;
  endsequence
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_upper_wr; s_wr(ram_req.upper && lock_q[3]) |=> !ram_wr_allow; endproperty
  a_upper_wr: assert property (p_upper_wr) else $error("upper write let through");
  property p_upper_rd; s_rd(ram_req.upper && lock_q[3]) |=> ram_rdata == 8'hFF; endproperty
  a_upper_rd: assert property (p_upper_rd) else $error("upper read not blanked");
  property p_read_block; s_rd(up_low && lock_q[4]) |=> ram_rdata == 8'hFF; endproperty
  a_read_block: assert property (p_read_block) else $error("low upper read seen");
  property p_write_block; s_wr(up_low && lock_q[5]) |=> !ram_wr_allow; endproperty
  a_write_block: assert property (p_write_block) else $error("low upper write seen");
  property p_mask_write;
    s_wr((ram_req.upper || ram_req.bank == 2'h0) && lock_q[6]) |=> !ram_wr_allow;
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("masked write let through");
  property p_lock_rd; s_rd(low_win && lock_q[7]) |=> ram_rdata == 8'hFF; endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("locked read not blanked");
  property p_open_wr; s_wr(lock_q == 8'h00) |=> ram_wr_allow; endproperty
  a_open_wr: assert property (p_open_wr) else $error("free write refused");
  property p_century; !$past(rst) |-> century_match == $past(cent_hit); endproperty
  a_century: assert property (p_century) else $error("century match wrong");
  property p_led_low;
    pin_q[2] && led_q[7:6] == 2'h1 |=> led_cs_pin_oe && !led_cs_pin_out;
  endproperty
  a_led_low: assert property (p_led_low) else $error("led not driven low");
  property p_led_float; pin_q[2] && led_q[7] == led_q[6] |=> !led_cs_pin_oe; endproperty
  a_led_float: assert property (p_led_float) else $error("led not floating");
endmodule : apc_cfg_bank_checker

// [tb/apc_cfg_bank_bench.sv]
// Self-checking bench for the APC configuration bank
`timescale 1ns/10ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, a); end end
module apc_cfg_bank_bench;
  logic                        clk_sys = 1'b0;
  logic                        rst = 1'b1;
  logic                        master_reset_pin = 1'b0;
  logic [7:0]                  reg_addr = 8'h00;
  logic [7:0]                  reg_wdata = 8'h00;
  logic                        reg_wr = 1'b0;
  logic                        reg_rd = 1'b0;
  logic [7:0]                  reg_rdata;
  apc_cfg_pkg::ram_access_type ram_req = '0;
  logic [7:0]                  ram_rdata_raw = 8'h00;
  logic                        ram_wr_allow;
  logic [7:0]                  ram_rdata;
  logic [7:0]                  century_now = 8'h00;
  logic                        century_match;
  logic [6:0]                  pin_drv = 7'h00;
  logic                        chip_select_zero = 1'b0;
  wire  [9:0]                  routed;
  logic                        led_cs_pin_out;
  logic                        led_cs_pin_oe;
  apc_cfg_pkg::event_hit_type  event_hit;
  int                          failures = 0;
  int                          check_count = 0;
  int                          hit_count = 0;
  int                          hit_sel = 0;
  logic [7:0]                  adr [5] = '{8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C};
  logic [7:0]                  val [5] = '{8'h59, 8'h5F, 8'h45, 8'hFF, 8'hC5};
  logic [7:0]                  rbk [5] = '{8'h59, 8'h5F, 8'h45, 8'h7F, 8'hC5};
  logic [7:0]                  locks [6] = '{8'h00, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
  // Short blink half period keeps the run small
  apc_cfg_bank #(.BLINK_HALF_CYCLES(4)) u_apc_cfg_bank (
    .clk_sys, .rst, .master_reset_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ram_req, .ram_rdata_raw, .ram_wr_allow, .ram_rdata, .century_now, .century_match,
    .pad_pme_a_gp16(pin_drv[2]), .pad_pme_b_gp15(pin_drv[3]), .pad_irrx_a_gp24(pin_drv[4]),
    .pad_irrx_b_gp37(pin_drv[5]), .pad_ri_b_gp33(pin_drv[6]), .pad_gp_pin_ten(pin_drv[1]),
    .gp_pin_twelve(pin_drv[0]), .chip_select_zero, .pm_event_in_a(routed[9]),
    .gp_pin_sixteen(routed[8]), .pm_event_in_b(routed[7]), .gp_pin_fifteen(routed[6]),
    .infrared_rx_a(routed[5]), .gp_pin_twentyfour(routed[4]), .infrared_rx_b(routed[3]),
    .gp_pin_thirtyseven(routed[2]), .ring_indicate_b(routed[1]),
    .gp_pin_thirtythree(routed[0]), .led_cs_pin_out, .led_cs_pin_oe, .event_hit);
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (event_hit[hit_sel] === 1'b1) hit_count++;
  task automatic final_report;
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    `CHK("reg_rdata", e, reg_rdata)
  endtask : chk_reg
  task automatic ram_op(input logic [7:0] lk, input logic up, input logic [1:0] bk,
                        input logic [6:0] off);
    logic win;
    logic low;
    logic bw;
    logic br;
    win = !up && off >= 7'h38 && off <= 7'h3F;
    low = up && off <= 7'h1F;
    bw  = (lk[3] && up) || (lk[5] && low) || (lk[6] && (up || bk == 2'h0)) || (lk[7] && win);
    br  = (lk[3] && up) || (lk[4] && low) || (lk[7] && win);
    @(posedge clk_sys);
    ram_req <= {1'b0, 1'b1, up, bk, off};
    @(posedge clk_sys);
    ram_req       <= {1'b1, 1'b0, up, bk, off};
    ram_rdata_raw <= {1'b1, off};
    @(negedge clk_sys);
    `CHK("ram_wr_allow", !bw, ram_wr_allow)
    @(posedge clk_sys);
    ram_req <= '0;
    @(negedge clk_sys);
    `CHK("ram_rdata", br ? 8'hFF : {1'b1, off}, ram_rdata)
  endtask : ram_op
  task automatic t_ram_guard;
    foreach (locks[i]) begin
      @(posedge clk_sys);
      master_reset_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      master_reset_pin <= 1'b0;
      repeat (8) @(posedge clk_sys);
      chk_reg(8'h47, 8'h00);
      wr(8'h47, locks[i] | 8'h07);
      wr(8'h47, 8'h00);
      chk_reg(8'h47, locks[i]);
      ram_op(locks[i], 1'b1, 2'h1, 7'h10);
      ram_op(locks[i], 1'b1, 2'h1, 7'h1F);
      ram_op(locks[i], 1'b1, 2'h1, 7'h20);
      ram_op(locks[i], 1'b0, 2'h0, 7'h38);
      ram_op(locks[i], 1'b0, 2'h2, 7'h3F);
      ram_op(locks[i], 1'b0, 2'h1, 7'h40);
      ram_op(locks[i], 1'b0, 2'h0, 7'h37);
    end
    foreach (adr[i]) chk_reg(adr[i], rbk[i]);
  endtask : t_ram_guard
  task automatic cent_case(input logic [7:0] r, input logic [7:0] n, input logic e);
    wr(8'h48, r);
    century_now <= n;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK("century_match", e, century_match)
  endtask : cent_case
  task automatic led_case(input logic [7:0] pd, input logic [7:0] md, input logic cs,
                          input logic [1:0] e);
    wr(8'h49, pd);
    wr(8'h4A, md);
    chip_select_zero <= cs;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK("led_pin", e, {led_cs_pin_oe, led_cs_pin_out & led_cs_pin_oe & !md[7]})
  endtask : led_case
  task automatic route_case(input logic [7:0] pd, input logic [7:0] ir, input logic pins);
    logic [9:0] e;
    e = {pd[0], !pd[0], pd[1], !pd[1], !pd[3], pd[3], !pd[4], pd[4], !ir[6], ir[6]};
    wr(8'h49, pd);
    wr(8'h4B, ir);
    pin_drv <= pins ? 7'h7C : 7'h00;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK("routed", e & {10{pins}}, routed)
  endtask : route_case
  task automatic ev_run(input logic [7:0] a, input logic [7:0] base, input int sh,
                        input int pin, input int hit);
    logic [2:0] c;
    hit_sel = hit;
    pin_drv <= 7'h00;
    for (int k = 0; k < 8; k++) begin
      c = k[2:0];
      wr(a, base | (8'(c) << sh));
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK("hit_low", c == 3'h0, event_hit[hit])
      hit_count = 0;
      @(posedge clk_sys);
      pin_drv[pin] <= 1'b1;
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK("hit_high", c == 3'h1, event_hit[hit])
      @(posedge clk_sys);
      pin_drv[pin] <= 1'b0;
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      if (c > 3'h1) `CHK("hit_edges", int'(c[2] & c[1]) + int'(c[2] & c[0]), hit_count)
    end
  endtask : ev_run
  initial begin
    logic o;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    chk_reg(8'h47, 8'h00);
    chk_reg(8'h48, 8'h00);
    chk_reg(8'h49, 8'hA0);
    chk_reg(8'h4A, 8'h2D);
    chk_reg(8'h4B, 8'h2D);
    chk_reg(8'h4C, 8'h2D);
    chk_reg(8'h50, 8'h00);
    foreach (adr[i]) wr(adr[i], val[i]);
    foreach (adr[i]) chk_reg(adr[i], rbk[i]);
    t_ram_guard();
    cent_case(8'h21, 8'h21, 1'b1);
    cent_case(8'h21, 8'h22, 1'b0);
    cent_case(8'h3F, 8'hFF, 1'b1);
    cent_case(8'hC5, 8'h13, 1'b1);
    cent_case(8'h85, 8'h13, 1'b0);
    led_case(8'h00, 8'h2D, 1'b1, 2'h3);
    led_case(8'h00, 8'h2D, 1'b0, 2'h2);
    led_case(8'h04, 8'h40, 1'b1, 2'h2);
    led_case(8'h04, 8'h00, 1'b1, 2'h0);
    led_case(8'h04, 8'hC0, 1'b1, 2'h0);
    led_case(8'h04, 8'h80, 1'b0, 2'h2);
    o = led_cs_pin_out;
    repeat (4) @(negedge clk_sys);
    `CHK("led_blink", !o, led_cs_pin_out)
    repeat (4) @(negedge clk_sys);
    `CHK("led_blink", o, led_cs_pin_out)
    route_case(8'h0B, 8'h40, 1'b1);
    route_case(8'h10, 8'h00, 1'b1);
    route_case(8'h0B, 8'h40, 1'b0);
    ev_run(8'h49, 8'h03, 5, 1, 5);
    ev_run(8'h4A, 8'h00, 0, 2, 4);
    ev_run(8'h4A, 8'h00, 3, 3, 3);
    ev_run(8'h4B, 8'h00, 0, 4, 2);
    ev_run(8'h4B, 8'h00, 3, 5, 1);
    ev_run(8'h4C, 8'h00, 0, 0, 0);
    final_report();
  end
  // Run needs under five thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    final_report();
  end
endmodule : apc_cfg_bank_bench
bind apc_cfg_bank apc_cfg_bank_checker u_apc_cfg_bank_checker (
  .clk_sys(clk_sys), .rst(rst), .master_reset_pin(master_reset_pin), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .ram_req(ram_req), .ram_wr_allow(ram_wr_allow),
  .ram_rdata(ram_rdata), .century_now(century_now), .century_match(century_match),
  .led_cs_pin_out(led_cs_pin_out), .led_cs_pin_oe(led_cs_pin_oe));
